/* tcas_regs.svh */
/*
 Constants of the temperature conversion and alarm sequencer: register
 offsets, configuration fields, reset values and conversion times.
 Assumes a 25 MHz core clock; no process or assignment lives here.
*/
`ifndef TCAS_REGS_SVH
`define TCAS_REGS_SVH

`define TCAS_ADDR_RES_HI 8'h00
`define TCAS_ADDR_RES_LO 8'h01
`define TCAS_ADDR_CFG 8'h03
`define TCAS_ADDR_UPPER_HI 8'h04
`define TCAS_ADDR_UPPER_LO 8'h05
`define TCAS_ADDR_LOWER_HI 8'h06
`define TCAS_ADDR_LOWER_LO 8'h07
`define TCAS_ADDR_SEVERE_HI 8'h08
`define TCAS_ADDR_SEVERE_LO 8'h09
`define TCAS_ADDR_HYST 8'h0a

`define TCAS_CFG_QUEUE_LSB 0
`define TCAS_CFG_LIMIT_POL 2
`define TCAS_CFG_CRIT_POL 3
`define TCAS_CFG_INTR_MODE 4
`define TCAS_CFG_MODE_LSB 5
`define TCAS_CFG_RES16 7

`define TCAS_CFG_RST 8'h00
`define TCAS_UPPER_RST 16'h2000
`define TCAS_LOWER_RST 16'h0500
`define TCAS_SEVERE_RST 16'h4980
`define TCAS_HYST_RST 8'h05

`define TCAS_CLK_HZ 25000000
`define TCAS_KHZ (`TCAS_CLK_HZ / 1000)
`define TCAS_CONV_MS 240
`define TCAS_FAST_MS 6
`define TCAS_SHORT_MS 60
`define TCAS_REST_MS 940
`define TCAS_WAKE_MS 1
`define TCAS_CONV_CYC (`TCAS_CONV_MS * `TCAS_KHZ)
`define TCAS_FAST_CYC (`TCAS_FAST_MS * `TCAS_KHZ)
`define TCAS_SHORT_CYC (`TCAS_SHORT_MS * `TCAS_KHZ)
`define TCAS_REST_CYC (`TCAS_REST_MS * `TCAS_KHZ)
`define TCAS_WAKE_CYC (`TCAS_WAKE_MS * `TCAS_KHZ)

`endif

/* tcas_pkg.sv */
/*
 Types of the temperature conversion and alarm sequencer.
 Assumes nothing of its surroundings.
*/
`default_nettype none
package tcas_pkg;
   // sequencer states
   typedef enum logic [1:0] {SEQ_WAKE, SEQ_CONV, SEQ_IDLE, SEQ_OFF} tcas_seq_t;
   // operating mode field, in the order of its two-bit code
   typedef enum logic [1:0] {MODE_CONT, MODE_ONESHOT, MODE_SPS, MODE_OFF} tcas_mode_t;
endpackage : tcas_pkg
`default_nettype wire

/* tcas_core.sv */
/*
 Conversion sequencer, setpoint registers, fault queue and the two
 open-drain alarm pins of the temperature sensor.
 Assumes a serial-bus slave on linkClk issuing one register access at a
 time, and an analog front end whose code on sensorCode is valid in the clk
 domain whenever a conversion ends.
*/
`include "tcas_regs.svh"
`timescale 1ns/10ps
`default_nettype none
module tcas_core #(
   parameter int unsigned CONV_CYC = `TCAS_CONV_CYC,
   parameter int unsigned FAST_CYC = `TCAS_FAST_CYC,
   parameter int unsigned SHORT_CYC = `TCAS_SHORT_CYC,
   parameter int unsigned REST_CYC = `TCAS_REST_CYC,
   parameter int unsigned WAKE_CYC = `TCAS_WAKE_CYC
) (
   input wire logic clk, // core clock, 25 MHz
   input wire logic rstn, // synchronous reset, active low
   input wire logic linkClk, // clock of the serial-bus slave
   input wire logic linkReqValid, // access request, held until answered
   input wire logic linkReqWrite, // 1 write, 0 read
   input wire logic [7:0] linkReqAddr, // register address
   input wire logic [7:0] linkReqWdata, // write byte
   output logic linkBusy, // access in flight
   output logic linkRspValid, // access finished pulse
   output logic [7:0] linkRspRdata, // read byte
   input wire logic [15:0] sensorCode, // front-end result code
   output logic convActive, // front end converting
   output logic shutdown, // front end powered down
   output logic limitAlarmPinOut, // open-drain level, always low
   output logic limitAlarmPinOe, // pulls limit pin low
   output logic criticalAlarmPinOut, // open-drain level, always low
   output logic criticalAlarmPinOe // pulls critical pin low
);
   localparam logic [24:0] CONV_LOAD = 25'(CONV_CYC - 1);
   localparam logic [24:0] FAST_LOAD = 25'(FAST_CYC - 1);
   localparam logic [24:0] SHORT_LOAD = 25'(SHORT_CYC - 1);
   localparam logic [24:0] REST_LOAD = 25'(REST_CYC - 1);
   localparam logic [24:0] WAKE_LOAD = 25'(WAKE_CYC - 1);

   // signed compare shared by every limit check
   function automatic logic isAbove(input logic [15:0] a, input logic [15:0] b);
      isAbove = $signed(a) > $signed(b);
   endfunction : isAbove

   // link side: reset synchroniser and request capture
   logic linkRstnS1, linkRstnS2;
   logic linkReqTog_reg, linkWrite_reg, linkBusy_reg, linkRspValid_reg;
   logic [7:0] linkAddr_reg, linkWdata_reg, linkRspRdata_reg;
   logic ackS1, ackS2, ackSeen;
   logic ackTog_reg;
   logic [7:0] rspData_reg;
   wire ackEdge = ackS2 ^ ackSeen;

   always_ff @(posedge linkClk) begin
      linkRstnS1 <= rstn;
      linkRstnS2 <= linkRstnS1;
   end

   // address and data stay frozen while busy, so the core may sample them
   always_ff @(posedge linkClk) begin
      if (!linkRstnS2) begin
         linkReqTog_reg <= 1'b0;
         linkWrite_reg <= 1'b0;
         linkAddr_reg <= 8'h00;
         linkWdata_reg <= 8'h00;
         linkBusy_reg <= 1'b0;
         linkRspValid_reg <= 1'b0;
         linkRspRdata_reg <= 8'h00;
         ackS1 <= 1'b0;
         ackS2 <= 1'b0;
         ackSeen <= 1'b0;
      end else begin
         ackS1 <= ackTog_reg;
         ackS2 <= ackS1;
         ackSeen <= ackS2;
         linkRspValid_reg <= ackEdge;
         if (ackEdge) begin
            linkBusy_reg <= 1'b0;
            linkRspRdata_reg <= rspData_reg; // stable until the next request
         end else if (linkReqValid && !linkBusy_reg && !linkRspValid_reg) begin // host still holds while answer stands
            linkReqTog_reg <= ~linkReqTog_reg;
            linkWrite_reg <= linkReqWrite;
            linkAddr_reg <= linkReqAddr;
            linkWdata_reg <= linkReqWdata;
            linkBusy_reg <= 1'b1;
         end
      end
   end

   // core side: request toggle synchroniser
   logic reqS1, reqS2, reqSeen;
   always_ff @(posedge clk) begin
      if (!rstn) begin
         reqS1 <= 1'b0;
         reqS2 <= 1'b0;
         reqSeen <= 1'b0;
      end else begin
         reqS1 <= linkReqTog_reg;
         reqS2 <= reqS1;
         reqSeen <= reqS2;
      end
   end

   // registers
   logic [7:0] cfg_reg, hysteresisValue_reg;
   logic [15:0] upperLimit_reg, lowerLimit_reg, severeLimit_reg;
   logic [15:0] resultWord_reg, tempLast_reg;
   logic [7:0] resLoHold_reg;
   logic resLock_reg;
   logic [2:0] faultCnt_reg;
   logic limitAct_reg, critAct_reg;
   tcas_pkg::tcas_seq_t seq_reg, seqNext;
   logic [24:0] timer_reg, loadVal;
   logic loadTimer;

   // access decode
   wire access = reqS2 ^ reqSeen;
   wire hostWrite = access && linkWrite_reg;
   wire hostRead = access && !linkWrite_reg;
   wire modeWrite = hostWrite && (linkAddr_reg == `TCAS_ADDR_CFG);
   wire [1:0] wModeBits = linkWdata_reg[`TCAS_CFG_MODE_LSB +: 2];
   wire tcas_pkg::tcas_mode_t wMode = tcas_pkg::tcas_mode_t'(wModeBits);
   wire tcas_pkg::tcas_mode_t curMode = tcas_pkg::tcas_mode_t'(cfg_reg[`TCAS_CFG_MODE_LSB +: 2]);
   wire intrMode = cfg_reg[`TCAS_CFG_INTR_MODE];
   wire res16 = cfg_reg[`TCAS_CFG_RES16];

   // read selection; the low result byte comes from the copy taken with the high byte when the access before it read the high byte
   wire [7:0] resLoByte = resLock_reg ? resLoHold_reg : resultWord_reg[7:0];
   wire [7:0] rdMux =
      (linkAddr_reg == `TCAS_ADDR_RES_HI) ? resultWord_reg[15:8] :
      (linkAddr_reg == `TCAS_ADDR_RES_LO) ? resLoByte :
      (linkAddr_reg == `TCAS_ADDR_CFG) ? cfg_reg :
      (linkAddr_reg == `TCAS_ADDR_UPPER_HI) ? upperLimit_reg[15:8] :
      (linkAddr_reg == `TCAS_ADDR_UPPER_LO) ? upperLimit_reg[7:0] :
      (linkAddr_reg == `TCAS_ADDR_LOWER_HI) ? lowerLimit_reg[15:8] :
      (linkAddr_reg == `TCAS_ADDR_LOWER_LO) ? lowerLimit_reg[7:0] :
      (linkAddr_reg == `TCAS_ADDR_SEVERE_HI) ? severeLimit_reg[15:8] :
      (linkAddr_reg == `TCAS_ADDR_SEVERE_LO) ? severeLimit_reg[7:0] :
      (linkAddr_reg == `TCAS_ADDR_HYST) ? hysteresisValue_reg : 8'h00;

   // limit checks on the new code and on the last stored one
   wire convDone = (seq_reg == tcas_pkg::SEQ_CONV) && (timer_reg == 25'h0000000);
   wire [15:0] tNow = res16 ? sensorCode : {sensorCode[15:3], 3'b000};
   wire [15:0] hystScaled = {5'h00, hysteresisValue_reg[3:0], 7'h00}; // whole degrees
   wire [15:0] highRel = upperLimit_reg - hystScaled;
   wire [15:0] lowRel = lowerLimit_reg + hystScaled;
   wire [15:0] critRel = severeLimit_reg - hystScaled;
   wire hiF = isAbove(tNow, upperLimit_reg);
   wire loF = isAbove(lowerLimit_reg, tNow);
   wire critF = isAbove(tNow, severeLimit_reg);
   wire anyF = hiF || loF || critF;
   wire limitBackNow = isAbove(highRel, tNow) && isAbove(tNow, lowRel);
   wire critBackNow = isAbove(critRel, tNow);
   wire limitBackLast = isAbove(highRel, tempLast_reg) && isAbove(tempLast_reg, lowRel);
   wire critBackLast = isAbove(critRel, tempLast_reg);

   // fault queue: count saturates at four
   wire [2:0] need = {1'b0, cfg_reg[`TCAS_CFG_QUEUE_LSB +: 2]} + 3'h1;
   wire [2:0] faultCntNext = !anyF ? 3'h0 :
      (faultCnt_reg == 3'h4) ? 3'h4 : faultCnt_reg + 3'h1;
   wire qualified = anyF && (faultCntNext >= need);

   // alarm set and release; a set in the same cycle as a release wins
   wire setLimit = convDone && qualified && (hiF || loF);
   wire setCrit = convDone && qualified && critF;
   wire clrLimit = (convDone && !intrMode && limitBackNow) ||
      (hostRead && intrMode) ||
      (modeWrite && !intrMode && limitBackLast);
   wire clrCrit = (convDone && !intrMode && critBackNow) ||
      (hostRead && intrMode) ||
      (modeWrite && !intrMode && critBackLast);
   wire limitNext = setLimit ? 1'b1 : (clrLimit ? 1'b0 : limitAct_reg);
   wire critNext = setCrit ? 1'b1 : (clrCrit ? 1'b0 : critAct_reg);

   // flags only in comparator mode and 13-bit format
   wire [2:0] flags = intrMode ? 3'b000 : {critF, hiF, loF};
   wire [15:0] resultNext = res16 ? sensorCode : {sensorCode[15:3], flags};

   // register writes
   always_ff @(posedge clk) begin
      if (!rstn) begin
         cfg_reg <= `TCAS_CFG_RST;
         upperLimit_reg <= `TCAS_UPPER_RST;
         lowerLimit_reg <= `TCAS_LOWER_RST;
         severeLimit_reg <= `TCAS_SEVERE_RST;
         hysteresisValue_reg <= `TCAS_HYST_RST;
      end else if (hostWrite) begin
         case (linkAddr_reg)
            `TCAS_ADDR_CFG: cfg_reg <= linkWdata_reg;
            `TCAS_ADDR_UPPER_HI: upperLimit_reg[15:8] <= linkWdata_reg;
            `TCAS_ADDR_UPPER_LO: upperLimit_reg[7:0] <= linkWdata_reg;
            `TCAS_ADDR_LOWER_HI: lowerLimit_reg[15:8] <= linkWdata_reg;
            `TCAS_ADDR_LOWER_LO: lowerLimit_reg[7:0] <= linkWdata_reg;
            `TCAS_ADDR_SEVERE_HI: severeLimit_reg[15:8] <= linkWdata_reg;
            `TCAS_ADDR_SEVERE_LO: severeLimit_reg[7:0] <= linkWdata_reg;
            `TCAS_ADDR_HYST: hysteresisValue_reg <= linkWdata_reg;
            default: ;
         endcase
      end
   end

   // answer and result hold; whole word replaced only at a finished conversion
   always_ff @(posedge clk) begin
      if (!rstn) begin
         ackTog_reg <= 1'b0;
         rspData_reg <= 8'h00;
         resultWord_reg <= 16'h0000;
         tempLast_reg <= 16'h0000;
         resLoHold_reg <= 8'h00;
         resLock_reg <= 1'b0;
      end else begin
         if (access) begin
            ackTog_reg <= ~ackTog_reg;
            rspData_reg <= rdMux;
         end
         if (convDone) begin
            resultWord_reg <= resultNext;
            tempLast_reg <= tNow;
         end
         if (hostRead && linkAddr_reg == `TCAS_ADDR_RES_HI) begin
            resLoHold_reg <= resultWord_reg[7:0];
            resLock_reg <= 1'b1;
         end else if (access) begin
            resLock_reg <= 1'b0;
         end
      end
   end

   // sequencer next state; a mode write to shutdown, one-shot or once-per-second, or any mode write in shutdown, takes priority over the timer
   always_comb begin
      seqNext = seq_reg;
      loadTimer = 1'b0;
      loadVal = CONV_LOAD;
      if (modeWrite && wMode == tcas_pkg::MODE_OFF) begin
         seqNext = tcas_pkg::SEQ_OFF;
      end else if (modeWrite && wMode == tcas_pkg::MODE_ONESHOT) begin
         seqNext = tcas_pkg::SEQ_CONV;
         loadTimer = 1'b1;
      end else if (modeWrite && wMode == tcas_pkg::MODE_SPS) begin
         seqNext = tcas_pkg::SEQ_CONV;
         loadTimer = 1'b1;
         loadVal = SHORT_LOAD;
      end else if (modeWrite && seq_reg == tcas_pkg::SEQ_OFF) begin
         seqNext = tcas_pkg::SEQ_WAKE;
         loadTimer = 1'b1;
         loadVal = WAKE_LOAD;
      end else if (timer_reg == 25'h0000000) begin
         case (seq_reg)
            tcas_pkg::SEQ_WAKE: begin
               seqNext = tcas_pkg::SEQ_CONV;
               loadTimer = 1'b1;
            end
            tcas_pkg::SEQ_CONV: begin
               case (curMode)
                  tcas_pkg::MODE_CONT: begin
                     seqNext = tcas_pkg::SEQ_CONV;
                     loadTimer = 1'b1;
                  end
                  tcas_pkg::MODE_SPS: begin
                     seqNext = tcas_pkg::SEQ_IDLE;
                     loadTimer = 1'b1;
                     loadVal = REST_LOAD;
                  end
                  default: seqNext = tcas_pkg::SEQ_OFF;
               endcase
            end
            tcas_pkg::SEQ_IDLE: begin
               seqNext = tcas_pkg::SEQ_CONV;
               loadTimer = 1'b1;
               loadVal = SHORT_LOAD;
            end
            default: seqNext = seq_reg; // shutdown waits for a mode write
         endcase
      end
   end

   // sequencer, timer, fault count and pins; first conversion is the fast one
   always_ff @(posedge clk) begin
      if (!rstn) begin
         seq_reg <= tcas_pkg::SEQ_CONV;
         timer_reg <= FAST_LOAD;
         faultCnt_reg <= 3'h0;
         limitAct_reg <= 1'b0;
         critAct_reg <= 1'b0;
         convActive <= 1'b1;
         shutdown <= 1'b0;
         limitAlarmPinOe <= 1'b0;
         criticalAlarmPinOe <= 1'b0;
      end else begin
         seq_reg <= seqNext;
         timer_reg <= loadTimer ? loadVal : (timer_reg == 25'h0000000 ? timer_reg : timer_reg - 25'h0000001);
         if (convDone) begin
            faultCnt_reg <= faultCntNext;
         end
         limitAct_reg <= limitNext;
         critAct_reg <= critNext;
         convActive <= seqNext == tcas_pkg::SEQ_CONV;
         shutdown <= seqNext == tcas_pkg::SEQ_OFF;
         limitAlarmPinOe <= limitNext ^ cfg_reg[`TCAS_CFG_LIMIT_POL];
         criticalAlarmPinOe <= critNext ^ cfg_reg[`TCAS_CFG_CRIT_POL];
      end
   end

   // the pins only ever pull low
   always_ff @(posedge clk) begin
      limitAlarmPinOut <= 1'b0;
      criticalAlarmPinOut <= 1'b0;
   end

   assign linkBusy = linkBusy_reg;
   assign linkRspValid = linkRspValid_reg;
   assign linkRspRdata = linkRspRdata_reg;

   // checks
   property p_cont_len;
      @(posedge clk) disable iff (!rstn)
      (convDone && !modeWrite && curMode == tcas_pkg::MODE_CONT) |=>
         (seq_reg == tcas_pkg::SEQ_CONV) && (timer_reg == CONV_LOAD);
   endproperty
   a_cont_len: assert property (p_cont_len) else $error("continuous conversion not restarted at full length");

   property p_oneshot;
      @(posedge clk) disable iff (!rstn)
      (modeWrite && wMode == tcas_pkg::MODE_ONESHOT) |=>
         (seq_reg == tcas_pkg::SEQ_CONV) && (timer_reg == CONV_LOAD) && convActive;
   endproperty
   a_oneshot: assert property (p_oneshot) else $error("one-shot write did not start a conversion");

   property p_oneshot_off;
      @(posedge clk) disable iff (!rstn)
      (convDone && !modeWrite && curMode == tcas_pkg::MODE_ONESHOT) |=> shutdown ##1 shutdown;
   endproperty
   a_oneshot_off: assert property (p_oneshot_off) else $error("one-shot did not end in shutdown");

   property p_sps_rest;
      @(posedge clk) disable iff (!rstn)
      (convDone && !modeWrite && curMode == tcas_pkg::MODE_SPS) |=>
         (seq_reg == tcas_pkg::SEQ_IDLE) && (timer_reg == REST_LOAD) && !convActive;
   endproperty
   a_sps_rest: assert property (p_sps_rest) else $error("once-per-second idle period wrong");

   property p_stay_off;
      @(posedge clk) disable iff (!rstn)
      (seq_reg == tcas_pkg::SEQ_OFF && !modeWrite) |=> (seq_reg == tcas_pkg::SEQ_OFF) && !convActive;
   endproperty
   a_stay_off: assert property (p_stay_off) else $error("conversion started during shutdown");

   property p_wake;
      @(posedge clk) disable iff (!rstn)
      (modeWrite && wMode == tcas_pkg::MODE_CONT && seq_reg == tcas_pkg::SEQ_OFF) |=>
         (seq_reg == tcas_pkg::SEQ_WAKE) && (timer_reg == WAKE_LOAD);
   endproperty
   a_wake: assert property (p_wake) else $error("wake from shutdown not started");

   property p_intr_read;
      @(posedge clk) disable iff (!rstn)
      (hostRead && intrMode && !setLimit && !setCrit) |=> !limitAct_reg && !critAct_reg;
   endproperty
   a_intr_read: assert property (p_intr_read) else $error("read did not release alarms");

   property p_queue_hold;
      @(posedge clk) disable iff (!rstn)
      (convDone && anyF && faultCntNext < need && !limitAct_reg) |=> !limitAct_reg;
   endproperty
   a_queue_hold: assert property (p_queue_hold) else $error("alarm before fault queue filled");

   property p_queue_clear;
      @(posedge clk) disable iff (!rstn)
      (convDone && !anyF) |=> (faultCnt_reg == 3'h0);
   endproperty
   a_queue_clear: assert property (p_queue_clear) else $error("fault count not cleared");

   property p_result_stable;
      @(posedge clk) disable iff (!rstn)
      !convDone |=> $stable(resultWord_reg);
   endproperty
   a_result_stable: assert property (p_result_stable) else $error("result changed outside conversion end");

   property p_link_busy;
      @(posedge linkClk) disable iff (!linkRstnS2)
      (linkReqValid && !linkBusy_reg && !ackEdge && !linkRspValid_reg) |=> linkBusy_reg;
   endproperty
   a_link_busy: assert property (p_link_busy) else $error("request not taken");

   c_oneshot_done: cover property (@(posedge clk) disable iff (!rstn)
      convDone && curMode == tcas_pkg::MODE_ONESHOT);
   c_limit_alarm: cover property (@(posedge clk) disable iff (!rstn) $rose(limitAct_reg));
   c_intr_release: cover property (@(posedge clk) disable iff (!rstn)
      hostRead && intrMode && limitAct_reg);
endmodule : tcas_core
`default_nettype wire

/* tcas_link_host.sv */
/* serial-bus host model for the sequencer's register link.
 assumes a free-running linkClk and one access at a time. */
`timescale 1ns/10ps
`default_nettype none
module tcas_link_host (
   input wire logic linkClk, // link clock
   input wire logic linkRspValid, // access done
   input wire logic [7:0] linkRspRdata, // read byte
   output logic reqValid, // access request
   output logic reqWrite, // 1 write, 0 read
   output logic [7:0] reqAddr, // register address
   output logic [7:0] reqWdata // write byte
);
   // idle address and data lines start at a pattern, not at a guessable zero
   initial begin
      reqValid = 1'b0;
      reqWrite = 1'b0;
      reqAddr = 8'h5a;
      reqWdata = 8'ha5;
   end
   // request held whole until the response edge; stale lines inverted after
   task automatic access(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q,
      output logic ok);
      int n;
      n = 0;
      @(negedge linkClk);
      reqWrite = w;
      reqAddr = a;
      reqWdata = d;
      reqValid = 1'b1;
      do begin
         @(posedge linkClk);
         n++;
      end while (linkRspValid !== 1'b1 && n < 60);
      q = linkRspRdata;
      ok = (linkRspValid === 1'b1); // low when the wait ran out
      @(negedge linkClk);
      reqValid = 1'b0;
      reqAddr = ~a;
      reqWdata = ~d;
   endtask : access
endmodule : tcas_link_host
`default_nettype wire

/* testbench.sv */
/* self-checking bench of the conversion sequencer and alarm pins.
 assumes short conversion parameters and the link host model. */
`timescale 1ns/10ps
`default_nettype none
module testbench;
   localparam int CV = 40;
   localparam int SH = 20;
   localparam int RS = 30;
   localparam int WK = 5;
   logic clk, rstn, linkClk, rv, rw, bsy, rspV, cAct, sdn, lOut, lOe, cOut, cOe;
   logic [7:0] ra, rd, rdat, rq;
   logic [15:0] code;
   int seed, err_total, n_tests, cyc;
   tcas_core #(.CONV_CYC(CV), .FAST_CYC(10), .SHORT_CYC(SH), .REST_CYC(RS), .WAKE_CYC(WK)) tcas_core_inst (
      .clk(clk), .rstn(rstn), .linkClk(linkClk), .linkReqValid(rv), .linkReqWrite(rw),
      .linkReqAddr(ra), .linkReqWdata(rd), .linkBusy(bsy), .linkRspValid(rspV), .linkRspRdata(rdat),
      .sensorCode(code), .convActive(cAct), .shutdown(sdn), .limitAlarmPinOut(lOut),
      .limitAlarmPinOe(lOe), .criticalAlarmPinOut(cOut), .criticalAlarmPinOe(cOe));
   tcas_link_host tcas_link_host_inst (.linkClk(linkClk), .linkRspValid(rspV), .linkRspRdata(rdat),
      .reqValid(rv), .reqWrite(rw), .reqAddr(ra), .reqWdata(rd));
   // clocks of unrelated phase
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      linkClk = 1'b0;
      #7;
      forever #24 linkClk = ~linkClk;
   end
   // expected low result byte: flags in 13-bit mode, none in interrupt mode
   function automatic logic [7:0] exp_lo(input logic [15:0] c, input logic r16, input logic intr);
      logic signed [15:0] m;
      m = {c[15:3], 3'h0};
      return r16 ? c[7:0] : {c[7:3], ~intr & (m > 16'sh4980), ~intr & (m > 16'sh2000), ~intr & (m < 16'sh0500)};
   endfunction : exp_lo
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic op(input logic w, input logic [7:0] a, input logic [7:0] d);
      logic ok;
      tcas_link_host_inst.access(w, a, d, rq, ok);
      chk("link answer", {7'h00, ok}, 8'h01);
   endtask : op
   task automatic waitc(input int n);
      repeat (n) @(negedge clk);
   endtask : waitc
   // reads both result bytes and compares them
   task automatic res(input logic r16, input logic intr, input logic [15:0] c);
      op(1'b0, 8'h00, 8'h00);
      chk("result high", rq, c[15:8]);
      op(1'b0, 8'h01, 8'h00);
      chk("result low", rq, exp_lo(c, r16, intr));
      chk("link busy", bsy, 0);
   endtask : res
   task automatic close_out;
      $display("checks %0d errors %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   // hang guard
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         err_total++;
         close_out;
      end
   end
   initial begin
      seed = 32'hc855ebbd;
      err_total = 0;
      n_tests = 0;
      cyc = 0;
      rstn = 1'b0;
      code = 16'h0c80;
      waitc(10);
      rstn = 1'b1;
      waitc(14);
      chk("convActive", cAct, 1);
      res(0, 0, code);
      // power-up setpoints, then one setpoint byte written and read back
      op(1'b0, 8'h04, 8'h00);
      chk("upper limit", rq, 8'h20);
      op(1'b0, 8'h06, 8'h00);
      chk("lower limit", rq, 8'h05);
      op(1'b0, 8'h08, 8'h00);
      chk("severe limit", rq, 8'h49);
      op(1'b0, 8'h09, 8'h00);
      chk("severe limit low", rq, 8'h80);
      op(1'b0, 8'h0a, 8'h00);
      chk("hysteresis", rq, 8'h05);
      op(1'b1, 8'h05, 8'h08);
      op(1'b0, 8'h05, 8'h00);
      chk("upper limit low", rq, 8'h08);
      op(1'b1, 8'h05, 8'h00);
      // random in-range codes in both formats
      for (int i = 0; i < 6; i++) begin
         op(1'b1, 8'h03, {i[0], 7'h00});
         code = 16'h0600 + 16'($random(seed) & 32'h0fff);
         waitc(2 * CV + 4);
         res(i[0], 0, code);
         chk("limit pin", lOe, 0);
      end
      op(1'b1, 8'h03, 8'h00);
      code = 16'h4b00;
      waitc(2 * CV + 4);
      chk("limit pin", lOe, 1);
      chk("critical pin", cOe, 1);
      res(0, 0, code);
      code = 16'h2300;
      waitc(2 * CV + 4);
      chk("critical pin", cOe, 0);
      chk("limit pin", lOe, 1);
      code = 16'h0c80;
      waitc(2 * CV + 4);
      chk("limit pin", lOe, 0);
      // four-deep fault queue
      op(1'b1, 8'h03, 8'h03);
      code = 16'h2300;
      waitc(75);
      chk("queued pin", lOe, 0);
      waitc(95);
      chk("queued pin", lOe, 1);
      chk("pin drive level", {6'h00, lOut, cOut}, 8'h00);
      code = 16'h0c80;
      waitc(2 * CV + 4);
      // interrupt mode set, then shutdown, then any read releases
      op(1'b1, 8'h03, 8'h10);
      code = 16'h2300;
      waitc(2 * CV + 4);
      chk("irq pin", lOe, 1);
      op(1'b1, 8'h03, 8'h70);
      waitc(3);
      chk("shutdown", sdn, 1);
      op(1'b0, 8'h03, 8'h00);
      chk("config", rq, 8'h70);
      chk("irq pin", lOe, 0);
      op(1'b1, 8'h03, 8'h7c);
      waitc(3);
      chk("pin polarity", lOe, 1);
      chk("pin polarity", cOe, 1);
      code = 16'h0c80;
      waitc(CV + 4);
      chk("convActive", cAct, 0);
      res(0, 1, 16'h2300);
      // one-shot three times, host waits a whole conversion before reading
      for (int i = 0; i < 3; i++) begin
         code = (i == 2) ? 16'h4b00 : (i ? 16'h1000 : 16'h0c80);
         op(1'b1, 8'h03, 8'h20);
         chk("critical pin", cOe, 0);
         waitc(CV + 8);
         chk("critical pin", cOe, i == 2);
         chk("shutdown", sdn, 1);
         res(0, 0, code);
      end
      // once-per-second timing
      op(1'b1, 8'h03, 8'h40);
      waitc(2);
      chk("convActive", cAct, 1);
      waitc(SH + 3);
      chk("convActive", cAct, 0);
      waitc(RS + 5);
      chk("convActive", cAct, 1);
      op(1'b1, 8'h03, 8'h60);
      op(1'b1, 8'h03, 8'h00);
      waitc(WK + 5);
      chk("convActive", cAct, 1);
      chk("shutdown", sdn, 0);
      close_out;
   end
endmodule : testbench
`default_nettype wire
